// *** scan_cfg.svh ***
`ifndef SCAN_CFG_SVH
`define SCAN_CFG_SVH

// Line layout: masked black samples first, then image pixels
`define BLK_PIX 32
`define IMG_PIX 32
`define BLK_LAST 6'h1f
`define LINE_LAST 6'h3f
`define IMG_LAST 5'h1f

// Peak white at or below this raises the lamp fault
`define LAMP_MIN 8'h40

// Streak erase thresholds, brightness units
`define LS_THR1 8'h40
`define LS_THR2 8'h20
`define DS_THR1 8'h40
`define DS_THR2 8'h30
`define DS_THR3 8'h20

// Filter thresholds
`define EDGE_THR 8'h30
`define LOWD_THR 8'hc0
`define DOT_THR 8'h80
`define LW_OFF 8'h80

`define FIFO_DEPTH 32

`endif

// *** scan_pkg.sv ***
package scan_pkg;

  typedef logic [7:0] pix_t;

  typedef enum logic [3:0] {
    TEXT1 = 4'h0,
    TEXT2 = 4'h1,
    PHOTO1 = 4'h2,
    PHOTO2 = 4'h3,
    PHOTO3 = 4'h4,
    SPEC1 = 4'h5,
    SPEC2 = 4'h6,
    SPEC3 = 4'h7,
    SPEC4 = 4'h8,
    SPEC5 = 4'h9
  } orig_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_BLACK = 2'b01,
    S_IMAGE = 2'b10,
    S_EMIT = 2'b11
  } state_t;

endpackage : scan_pkg

// *** stream_if.sv ***
`timescale 1ns/1ps
interface stream_if #(parameter int W = 8) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if

// *** pixel_fifo.sv ***
`timescale 1ns/1ps
module pixel_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk, // Clock
  input wire logic arst_n, // Async reset, low
  input wire logic clr, // Empties the queue, wins over push
  stream_if.snk wr, // Fill side
  stream_if.src rd // Drain side
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // Full queue still takes a word when one leaves in the same cycle
  assign wr.ready = (cnt_q != (AW+1)'(DEPTH)) || rd.ready;
  assign rd.valid = cnt_q != '0;
  assign rd.data = mem_q[rp_q];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  // Pointers wrap by width, so DEPTH must be a power of two
  always_comb begin
    wp_d = wp_q + AW'(push);
    rp_d = rp_q + AW'(pop);
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    if (clr) begin
      wp_d = '0;
      rp_d = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push && !clr) begin
      mem_q[wp_q] <= wr.data;
    end
  end

  no_overflow_a: assert property (@(posedge clk) disable iff (!arst_n)
    cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count above depth");
  count_track_a: assert property (@(posedge clk) disable iff (!arst_n)
    (push && !pop && !clr) |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("fifo count missed a push");

endmodule : pixel_fifo

// *** scan_image_preprocess.sv ***
`timescale 1ns/1ps
`include "scan_cfg.svh"
module scan_image_preprocess (
  input wire logic mclk, // 125 MHz clock
  input wire logic arst_n, // Async reset, low
  input wire scan_pkg::pix_t pix_data, // Sensor video sample
  input wire logic pix_valid, // Sample present
  input wire logic pix_sol, // First sample of a line
  output logic pix_ready, // Sample accepted when high with valid
  input wire logic page_end, // Pulse after each scanned page
  input wire scan_pkg::orig_t orig_type, // Original type
  input wire logic [2:0] density_level, // Panel density
  input wire logic adf_mode, // Feeder scan, mirror lines
  input wire logic photo_gamma, // Scanner gamma curve: 1 photo, 0 text
  input wire logic [1:0] light_streak_erase_level, // 0 off
  input wire logic [1:0] dark_streak_erase_level, // 0 off
  input wire logic [2:0] edge_sharpen_strength, // Edge filter
  input wire logic [2:0] solid_sharpen_strength, // Solid filter
  input wire logic [2:0] low_density_line_strength, // Low-density filter
  input wire logic [1:0] isolated_dot_erase_level, // 0 off
  input wire logic [1:0] line_width_level, // 0 mode default
  input wire logic signed [3:0] density_gamma_adjust, // Curve shift
  output logic shade_busy, // Next lines are read as white plate
  output logic lamp_fault_code, // Lamp fault, held until the next shading acquisition ends
  output scan_pkg::pix_t ads_ref, // Line reference value
  output logic ads_ref_stb, // Reference value update pulse
  output scan_pkg::pix_t out_data, // Processed pixel
  output logic out_last, // Last pixel of a line
  output logic out_valid, // Output present
  input wire logic out_ready // Output taken
);

  function automatic scan_pkg::pix_t sat(input int v);
    return (v < 0) ? 8'h00 : (v > 255) ? 8'hff : 8'(v);
  endfunction : sat

  function automatic scan_pkg::pix_t avg(input scan_pkg::pix_t x, input scan_pkg::pix_t y);
    return 8'((9'(x) + 9'(y)) >> 1);
  endfunction : avg

  function automatic scan_pkg::pix_t min2(input scan_pkg::pix_t x, input scan_pkg::pix_t y);
    return (x < y) ? x : y;
  endfunction : min2

  stream_if #(.W(8)) sh_wr ();
  stream_if #(.W(8)) sh_rd ();
  stream_if #(.W(9)) o_wr ();
  stream_if #(.W(9)) o_rd ();

  scan_pkg::state_t state_q, state_d;
  logic [5:0] cnt_q, cnt_d;
  logic [4:0] emit_q, emit_d;
  logic [12:0] bsum_q, bsum_d;
  scan_pkg::pix_t black_q, black_d, peak_q, peak_d, lpeak_q, lpeak_d;
  scan_pkg::pix_t bg_q, bg_d, ref_q, ref_d;
  logic acq_q, acq_d, aln_q, aln_d, need_q, need_d;
  logic fault_q, fault_d, stb_q, stb_d;
  scan_pkg::orig_t ptype_q, ptype_d;
  logic [2:0] pdens_q, pdens_d;
  logic ads_on, set6, edge_ok, is_photo;
  logic img, lin0, acc, sh_clr;

  // Mode decode per original type
  assign ads_on = orig_type inside {scan_pkg::TEXT1, scan_pkg::TEXT2, scan_pkg::PHOTO2,
    scan_pkg::SPEC1, scan_pkg::SPEC2};
  assign set6 = ads_on || orig_type == scan_pkg::SPEC5;
  assign edge_ok = set6 || orig_type inside {scan_pkg::PHOTO1, scan_pkg::PHOTO3};
  assign is_photo = orig_type inside {scan_pkg::PHOTO1, scan_pkg::PHOTO2, scan_pkg::PHOTO3};

  // Correction of the incoming sample
  scan_pkg::pix_t wref, dblk, wblk, corr, gam, adsv;
  logic [5:0] p6, w6;
  logic [15:0] sq;
  always_comb begin
    wref = sh_rd.data;
    dblk = (pix_data > black_q) ? pix_data - black_q : 8'h00;
    wblk = (wref > black_q) ? wref - black_q : 8'h00;
    // Six-bit ratio hides tiny pixel-to-pixel sensor differences
    p6 = dblk[7:2];
    w6 = wblk[7:2];
    corr = (w6 == 6'h00 || p6 >= w6) ? 8'hff : 8'((14'(p6) * 14'h00ff) / 14'(w6));
    sq = 16'(8'hff - corr) * 16'(8'hff - corr);
    gam = photo_gamma ? 8'hff - sq[15:8] : corr;
    adsv = (ads_on && gam >= bg_q) ? 8'hff : gam;
  end

  assign img = state_q == scan_pkg::S_IMAGE;
  assign lin0 = acq_q && !aln_q;
  // Image samples wait for shading data; lines stall while emitting
  // Shading room is not consulted: it would loop back through the pop
  assign pix_ready = (state_q != scan_pkg::S_EMIT) && (!img || lin0 || sh_rd.valid);
  assign acc = pix_valid && pix_ready;
  assign sh_clr = (state_q == scan_pkg::S_IDLE) && acc && pix_sol && need_q && !acq_q;
  assign sh_wr.valid = acc && img;
  // First plate line stored raw, second averaged in; scans recirculate
  assign sh_wr.data = lin0 ? pix_data : (acq_q ? avg(pix_data, wref) : wref);
  assign sh_rd.ready = acc && img && !lin0;

  pixel_fifo #(.W(8), .DEPTH(`FIFO_DEPTH)) shade_fifo (
    .clk(mclk),
    .arst_n(arst_n),
    .clr(sh_clr),
    .wr(sh_wr),
    .rd(sh_rd)
  );

  // Line sequencing and shading control
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    emit_d = emit_q;
    bsum_d = bsum_q;
    black_d = black_q;
    peak_d = peak_q;
    lpeak_d = lpeak_q;
    bg_d = bg_q;
    ref_d = ref_q;
    acq_d = acq_q;
    aln_d = aln_q;
    need_d = need_q;
    fault_d = fault_q;
    stb_d = 1'b0;
    ptype_d = orig_type;
    pdens_d = density_level;
    case (state_q)
      scan_pkg::S_IDLE: begin
        if (acc && pix_sol) begin
          state_d = scan_pkg::S_BLACK;
          cnt_d = 6'h01;
          bsum_d = 13'(pix_data);
          if (!acq_q && need_q) begin
            acq_d = 1'b1;
            aln_d = 1'b0;
            need_d = 1'b0;
            peak_d = 8'h00;
          end
        end
      end
      scan_pkg::S_BLACK: begin
        if (acc) begin
          bsum_d = bsum_q + 13'(pix_data);
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == `BLK_LAST) begin
            black_d = bsum_d[12:5];
            lpeak_d = 8'h00;
            state_d = scan_pkg::S_IMAGE;
          end
        end
      end
      scan_pkg::S_IMAGE: begin
        if (acc) begin
          cnt_d = cnt_q + 6'h01;
          if (acq_q) begin
            if (pix_data > peak_q) peak_d = pix_data;
          end else if (gam > lpeak_q) begin
            lpeak_d = gam;
          end
          if (cnt_q == `LINE_LAST) begin
            state_d = scan_pkg::S_IDLE;
            if (lin0) begin
              aln_d = 1'b1;
            end else if (acq_q) begin
              acq_d = 1'b0;
              fault_d = peak_d <= `LAMP_MIN;
            end else begin
              state_d = scan_pkg::S_EMIT;
              emit_d = 5'h00;
              ref_d = lpeak_d;
              stb_d = ads_on;
              bg_d = ads_on ? lpeak_d : 8'hff;
            end
          end
        end
      end
      scan_pkg::S_EMIT: begin
        if (o_wr.ready) begin
          emit_d = emit_q + 5'h01;
          if (emit_q == `IMG_LAST) state_d = scan_pkg::S_IDLE;
        end
      end
      default: begin
        state_d = scan_pkg::S_IDLE;
      end
    endcase
    // Set wins: a request raised during acquisition queues the next one
    if (page_end) need_d = 1'b1;
    if (orig_type != ptype_q || density_level != pdens_q) need_d = 1'b1;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= scan_pkg::S_IDLE;
      cnt_q <= 6'h00;
      emit_q <= 5'h00;
      bsum_q <= 13'h0000;
      black_q <= 8'h00;
      peak_q <= 8'h00;
      lpeak_q <= 8'h00;
      bg_q <= 8'hff;
      ref_q <= 8'h00;
      acq_q <= 1'b0;
      aln_q <= 1'b0;
      need_q <= 1'b1;
      fault_q <= 1'b0;
      stb_q <= 1'b0;
      ptype_q <= scan_pkg::TEXT1;
      pdens_q <= 3'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      emit_q <= emit_d;
      bsum_q <= bsum_d;
      black_q <= black_d;
      peak_q <= peak_d;
      lpeak_q <= lpeak_d;
      bg_q <= bg_d;
      ref_q <= ref_d;
      acq_q <= acq_d;
      aln_q <= aln_d;
      need_q <= need_d;
      fault_q <= fault_d;
      stb_q <= stb_d;
      ptype_q <= ptype_d;
      pdens_q <= pdens_d;
    end
  end

  // Whole line held so neighbours and reversed order are both at hand
  scan_pkg::pix_t line_q [`IMG_PIX];
  always_ff @(posedge mclk) begin
    if (img && acc && !acq_q) begin
      line_q[cnt_q[4:0]] <= adsv;
    end
  end

  logic [4:0] kidx;
  scan_pkg::pix_t win [8];
  assign kidx = adf_mode ? `IMG_LAST - emit_q : emit_q;

  // Window around the emitted pixel, clamped at line ends
  for (genvar j = 0; j < 8; j++) begin : g_win
    int p;
    assign p = int'(kidx) + j - 4;
    assign win[j] = (p < 0) ? line_q[0] : (p > 31) ? line_q[31] : line_q[p[4:0]];
  end

  scan_pkg::pix_t a, c, s, mx, mn, dref, f, res, lthr, dthr, othr;
  logic [1:0] lw;
  int lap, st, r;
  always_comb begin
    a = win[3];
    c = win[5];
    s = win[4];
    lthr = (light_streak_erase_level == 2'h2) ? `LS_THR2 : `LS_THR1;
    mx = (win[0] > win[7]) ? win[0] : win[7];
    // Reference pixels four left and three right bound a six-wide gap
    if (light_streak_erase_level != 2'h0 && 9'(s) > 9'(mx) + 9'(lthr))
      s = avg(win[0], win[7]);
    dref = (dark_streak_erase_level == 2'h3) ? win[0] : win[2];
    case (dark_streak_erase_level)
      2'h1: dthr = `DS_THR1;
      2'h2: dthr = `DS_THR2;
      default: dthr = `DS_THR3;
    endcase
    mn = min2(dref, win[7]);
    if (dark_streak_erase_level != 2'h0 && 9'(s) + 9'(dthr) < 9'(mn))
      s = avg(dref, win[7]);
    lap = 2 * int'(s) - int'(a) - int'(c);
    // Strength 0 still filters lightly, hence the +1
    if (edge_ok && ((a > c) ? a - c : c - a) > `EDGE_THR) begin
      st = int'(edge_sharpen_strength) + 1;
    end else if (set6 && a >= `LOWD_THR && s >= `LOWD_THR && c >= `LOWD_THR) begin
      st = int'(low_density_line_strength) + 1;
    end else if (orig_type == scan_pkg::TEXT2) begin
      st = int'(solid_sharpen_strength) + 1;
    end else begin
      st = 0;
    end
    f = sat(int'(s) + ((lap * st) >>> 3));
    othr = `DOT_THR >> isolated_dot_erase_level;
    if (set6 && isolated_dot_erase_level != 2'h0 &&
        9'(a) > 9'(f) + 9'(othr) && 9'(c) > 9'(f) + 9'(othr)) begin
      f = avg(a, c);
    end
    lw = (line_width_level != 2'h0) ? line_width_level :
      ((orig_type == scan_pkg::SPEC2) ? 2'h1 : 2'h0);
    if (set6 && lw != 2'h0) f = min2(f, sat(int'(min2(a, c)) + int'(`LW_OFF >> lw)));
    // Photo curves take half the manual density step
    r = int'(f) - (is_photo ? int'(density_level) * 4 : int'(density_level) * 8)
      + int'(density_gamma_adjust) * 4;
    res = sat(r);
  end

  assign o_wr.valid = state_q == scan_pkg::S_EMIT;
  assign o_wr.data = {emit_q == `IMG_LAST, res};

  pixel_fifo #(.W(9), .DEPTH(`FIFO_DEPTH)) out_fifo (
    .clk(mclk),
    .arst_n(arst_n),
    .clr(1'b0),
    .wr(o_wr),
    .rd(o_rd)
  );

  assign out_valid = o_rd.valid;
  assign o_rd.ready = out_ready;
  assign out_data = o_rd.data[7:0];
  assign out_last = o_rd.data[8];
  assign shade_busy = need_q || acq_q;
  assign lamp_fault_code = fault_q;
  assign ads_ref = ref_q;
  assign ads_ref_stb = stb_q;

  logic acq_end, scan_end;
  assign acq_end = img && acc && acq_q && aln_q && cnt_q == `LINE_LAST;
  assign scan_end = img && acc && !acq_q && cnt_q == `LINE_LAST;

  black_avg_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (state_q == scan_pkg::S_BLACK && acc && cnt_q == `BLK_LAST)
    |=> black_q == $past(bsum_d[12:5]) && img) else $error("black average wrong");
  lamp_fault_a: assert property (@(posedge mclk) disable iff (!arst_n)
    acq_end |=> lamp_fault_code == ($past(peak_d) <= `LAMP_MIN) && !acq_q)
    else $error("lamp fault not set from peak");
  shade_room_a: assert property (@(posedge mclk) disable iff (!arst_n)
    sh_wr.valid |-> sh_wr.ready) else $error("shading write refused");
  page_shade_a: assert property (@(posedge mclk) disable iff (!arst_n)
    page_end |=> shade_busy ##1 shade_busy) else $error("page end lost shading request");
  change_shade_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (orig_type != ptype_q) |=> need_q) else $error("mode change lost shading request");
  ads_gate_a: assert property (@(posedge mclk) disable iff (!arst_n)
    scan_end |=> ads_ref_stb == $past(ads_on) ##1 !ads_ref_stb)
    else $error("reference strobe not gated by type");
  ads_value_a: assert property (@(posedge mclk) disable iff (!arst_n)
    scan_end |=> ads_ref == $past(lpeak_d)) else $error("reference value not line peak");
  mirror_a: assert property (@(posedge mclk) disable iff (!arst_n)
    (state_q == scan_pkg::S_EMIT && emit_q == 5'h00 && adf_mode) |-> kidx == `IMG_LAST)
    else $error("feeder line not reversed");
  emit_stall_a: assert property (@(posedge mclk) disable iff (!arst_n)
    scan_end |=> (!pix_ready && state_q == scan_pkg::S_EMIT) [*8])
    else $error("input accepted while line emits");

  acq_done_c: cover property (@(posedge mclk) disable iff (!arst_n) acq_end);
  adf_line_c: cover property (@(posedge mclk) disable iff (!arst_n)
    adf_mode && o_wr.valid && o_wr.ready && emit_q == `IMG_LAST);
  fault_c: cover property (@(posedge mclk) disable iff (!arst_n) $rose(lamp_fault_code));
  stall_c: cover property (@(posedge mclk) disable iff (!arst_n)
    o_wr.valid && !o_wr.ready);

endmodule : scan_image_preprocess

// *** sensor_model.sv ***
`timescale 1ns/1ps
module sensor_model (
  input wire logic mclk, // Clock
  input wire logic pix_ready, // Processor takes sample
  input wire logic hold_out, // Print side stalls
  output scan_pkg::pix_t pix_data, // Sample
  output logic pix_valid, // Sample present
  output logic pix_sol, // First sample of a line
  output logic out_ready // Print side takes word
);
  logic ok;
  assign out_ready = !hold_out;
  initial begin
    pix_valid = 1'b0;
    pix_sol = 1'b0;
    pix_data = 8'h00;
  end
  // Entered at a falling edge; the sample only moves after an edge that took it
  task automatic send_line(input scan_pkg::pix_t blk, input logic [255:0] img, input bit slow);
    for (int i = 0; i < 64; i++) begin
      pix_data = (i < 32) ? blk : img[8*(i-32) +: 8];
      pix_sol = (i == 0);
      pix_valid = 1'b1;
      do begin
        #3;
        ok = pix_ready;
        @(negedge mclk);
      end while (!ok);
      if (slow || i == 63) begin
        // Idle bus shows the inverse so a stale sample never looks valid
        pix_valid = 1'b0;
        pix_sol = 1'b0;
        pix_data = ~pix_data;
        @(negedge mclk);
      end
    end
  endtask : send_line
endmodule : sensor_model

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  typedef struct packed {
    scan_pkg::orig_t ot;
    logic pg;
    logic [2:0] dens;
    logic signed [3:0] adj;
    scan_pkg::pix_t px;
  } row_t;
  typedef struct packed {
    logic [1:0] lt;
    logic [1:0] dk;
    scan_pkg::pix_t base;
    scan_pkg::pix_t spot;
    logic gone;
  } streak_t;
  logic mclk, arst_n, pix_valid, pix_sol, pix_ready, page_end, adf_mode, photo_gamma;
  logic shade_busy, lamp_fault_code, ads_ref_stb, out_last, out_valid, out_ready, hold_out;
  logic [1:0] light_streak_erase_level, dark_streak_erase_level;
  logic [2:0] density_level;
  logic signed [3:0] density_gamma_adjust;
  scan_pkg::orig_t orig_type;
  scan_pkg::pix_t pix_data, ads_ref, out_data;
  scan_pkg::pix_t got[$];
  logic lastq[$];
  logic [255:0] img;
  int cycles, stb_n, fail_count, comparisons, s;
  logic auto_background_density;
  row_t rr;
  row_t rows[10] = '{
    '{scan_pkg::PHOTO1, 1'b1, 3'h3, 4'sh2, 8'h57}, '{scan_pkg::TEXT1, 1'b0, 3'h0, 4'sh0, 8'h80},
    '{scan_pkg::PHOTO3, 1'b0, 3'h7, 4'sh8, 8'hf0}, '{scan_pkg::TEXT2, 1'b1, 3'h1, 4'sh1, 8'h90},
    '{scan_pkg::SPEC3, 1'b0, 3'h2, 4'sh7, 8'hf0}, '{scan_pkg::PHOTO2, 1'b0, 3'h4, 4'sh0, 8'h60},
    '{scan_pkg::SPEC4, 1'b1, 3'h5, 4'shd, 8'h13}, '{scan_pkg::SPEC1, 1'b0, 3'h0, 4'sh3, 8'ha0},
    '{scan_pkg::SPEC5, 1'b0, 3'h6, 4'shf, 8'hc4}, '{scan_pkg::SPEC2, 1'b1, 3'h2, 4'sh0, 8'h30}};
  streak_t sk[7] = '{'{2'h1, 2'h0, 8'h60, 8'hf0, 1'b1}, '{2'h0, 2'h0, 8'h60, 8'hf0, 1'b0},
    '{2'h1, 2'h0, 8'h60, 8'h8c, 1'b0}, '{2'h2, 2'h0, 8'h60, 8'h8c, 1'b1},
    '{2'h0, 2'h1, 8'hc0, 8'h20, 1'b1}, '{2'h0, 2'h3, 8'hc0, 8'h20, 1'b1},
    '{2'h0, 2'h0, 8'hc0, 8'h20, 1'b0}};

  scan_image_preprocess dut (.mclk(mclk), .arst_n(arst_n), .pix_data(pix_data),
    .pix_valid(pix_valid), .pix_sol(pix_sol), .pix_ready(pix_ready), .page_end(page_end),
    .orig_type(orig_type), .density_level(density_level), .adf_mode(adf_mode),
    .photo_gamma(photo_gamma), .light_streak_erase_level(light_streak_erase_level),
    .dark_streak_erase_level(dark_streak_erase_level), .edge_sharpen_strength(3'h2),
    .solid_sharpen_strength(3'h1), .low_density_line_strength(3'h1),
    .isolated_dot_erase_level(2'h1), .line_width_level(2'h0),
    .density_gamma_adjust(density_gamma_adjust), .shade_busy(shade_busy),
    .lamp_fault_code(lamp_fault_code), .ads_ref(ads_ref), .ads_ref_stb(ads_ref_stb),
    .out_data(out_data), .out_last(out_last), .out_valid(out_valid), .out_ready(out_ready));
  sensor_model sm (.mclk(mclk), .pix_ready(pix_ready), .hold_out(hold_out),
    .pix_data(pix_data), .pix_valid(pix_valid), .pix_sol(pix_sol), .out_ready(out_ready));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cycles++;
    if (out_valid === 1'b1 && out_ready) begin
      got.push_back(out_data);
      lastq.push_back(out_last);
    end
    if (ads_ref_stb === 1'b1) stb_n++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  function automatic int corr_of(input int p, input logic pg);
    int c;
    c = ((p - 16) >> 2) >= 56 ? 255 : ((p - 16) >> 2) * 255 / 56;
    if (pg) c = 255 - (((255 - c) * (255 - c)) >> 8);
    return c;
  endfunction : corr_of

  function automatic int exp_pix(input int p, input row_t r);
    int c;
    logic ph;
    ph = r.ot inside {scan_pkg::PHOTO1, scan_pkg::PHOTO2, scan_pkg::PHOTO3};
    c = corr_of(p, r.pg) - int'(r.dens) * (ph ? 4 : 8) + int'(r.adj) * 4;
    return c < 0 ? 0 : (c > 255 ? 255 : c);
  endfunction : exp_pix

  task automatic chk8(input string nm, input scan_pkg::pix_t e, input scan_pkg::pix_t g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8

  task automatic chk1(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1

  task automatic wait_words(input int n);
    for (int k = 0; k < 400 && got.size() < n; k++) @(negedge mclk);
    chk8("word count", 8'(n), 8'(got.size()));
  endtask : wait_words

  task automatic scan(input logic [255:0] im, input bit slow);
    got.delete();
    lastq.delete();
    sm.send_line(8'h10, im, slow);
    wait_words(32);
    chk1("line end", 1'b1, lastq[31]);
    chk1("line start", 1'b0, lastq[0]);
  endtask : scan

  // Settle time covers an image line that may still drain to the output
  task automatic acquire(input scan_pkg::pix_t w, input logic fault);
    @(negedge mclk);
    chk1("busy before", 1'b1, shade_busy);
    repeat (2) sm.send_line(8'h10, {32{w}}, 1'b0);
    repeat (40) @(negedge mclk);
    chk1("busy after", 1'b0, shade_busy);
    chk1("lamp fault", fault, lamp_fault_code);
    got.delete();
    lastq.delete();
  endtask : acquire

  task automatic page();
    page_end = 1'b1;
    @(negedge mclk);
    page_end = 1'b0;
  endtask : page

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    arst_n = 1'b0;
    page_end = 1'b0;
    adf_mode = 1'b0;
    photo_gamma = 1'b0;
    hold_out = 1'b0;
    light_streak_erase_level = 2'h0;
    dark_streak_erase_level = 2'h0;
    density_level = 3'h0;
    density_gamma_adjust = 4'sh0;
    orig_type = scan_pkg::TEXT1;
    rr = '{scan_pkg::SPEC3, 1'b0, 3'h0, 4'sh0, 8'h00};
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    chk1("reset ready", 1'b1, pix_ready);
    chk1("reset busy", 1'b1, shade_busy);
    chk1("reset fault", 1'b0, lamp_fault_code);
    chk1("reset valid", 1'b0, out_valid);
    chk1("reset strobe", 1'b0, ads_ref_stb);
    chk8("reset ref", 8'h00, ads_ref);
    arst_n = 1'b1;
    foreach (rows[i]) begin
      orig_type = rows[i].ot;
      photo_gamma = rows[i].pg;
      density_level = rows[i].dens;
      density_gamma_adjust = rows[i].adj;
      repeat (2) @(negedge mclk);
      acquire(8'hf0, 1'b0);
      s = stb_n;
      scan({32{rows[i].px}}, i[0]);
      auto_background_density = rows[i].ot inside {scan_pkg::TEXT1, scan_pkg::TEXT2, scan_pkg::PHOTO2,
        scan_pkg::SPEC1, scan_pkg::SPEC2};
      chk8("strobes", 8'(auto_background_density), 8'(stb_n - s));
      if (auto_background_density) chk8("peak", 8'(corr_of(rows[i].px, rows[i].pg)), ads_ref);
      else foreach (got[j]) chk8("pixel", 8'(exp_pix(rows[i].px, rows[i])), got[j]);
    end
    orig_type = scan_pkg::SPEC3;
    photo_gamma = 1'b0;
    density_level = 3'h0;
    density_gamma_adjust = 4'sh0;
    repeat (2) @(negedge mclk);
    acquire(8'hf0, 1'b0);
    for (int j = 0; j < 32; j++) img[8*j +: 8] = 8'(8'h20 + 4 * j);
    scan(img, 1'b0);
    foreach (got[j]) chk8("platen", 8'(exp_pix(int'(img[8*j +: 8]), rr)), got[j]);
    adf_mode = 1'b1;
    scan(img, 1'b1);
    foreach (got[j]) chk8("feeder", 8'(exp_pix(int'(img[8*(31-j) +: 8]), rr)), got[j]);
    adf_mode = 1'b0;
    foreach (sk[i]) begin
      light_streak_erase_level = sk[i].lt;
      dark_streak_erase_level = sk[i].dk;
      img = {32{sk[i].base}};
      img[87:80] = sk[i].spot;
      scan(img, 1'b0);
      chk8("streak", 8'(exp_pix(int'(sk[i].gone ? sk[i].base : sk[i].spot), rr)), got[10]);
      chk8("beside", 8'(exp_pix(int'(sk[i].base), rr)), got[20]);
    end
    light_streak_erase_level = 2'h0;
    dark_streak_erase_level = 2'h0;
    img = {32{8'h60}};
    img[87:80] = 8'h20;
    orig_type = scan_pkg::SPEC5;
    repeat (2) @(negedge mclk);
    acquire(8'hf0, 1'b0);
    scan(img, 1'b0);
    chk8("dot erase", 8'h5b, got[10]);
    chk8("edge", 8'h76, got[9]);
    orig_type = scan_pkg::SPEC2;
    repeat (2) @(negedge mclk);
    acquire(8'hf0, 1'b0);
    scan(img, 1'b0);
    chk8("line width", 8'h52, got[9]);
    orig_type = scan_pkg::TEXT1;
    density_level = 3'h2;
    repeat (2) @(negedge mclk);
    acquire(8'hf0, 1'b0);
    scan({32{8'h80}}, 1'b0);
    chk8("line peak", 8'(corr_of(8'h80, 1'b0)), ads_ref);
    scan({32{8'h80}}, 1'b1);
    chk8("tracked", 8'hef, got[5]);
    hold_out = 1'b1;
    got.delete();
    lastq.delete();
    sm.send_line(8'h10, {32{8'h60}}, 1'b0);
    sm.send_line(8'h10, {32{8'h70}}, 1'b0);
    repeat (40) @(negedge mclk);
    chk1("ready in stall", 1'b0, pix_ready);
    chk1("held word", 1'b1, out_valid);
    chk8("stalled words", 8'h00, 8'(got.size()));
    hold_out = 1'b0;
    wait_words(64);
    chk1("second end", 1'b1, lastq[63]);
    page();
    acquire(8'h40, 1'b1);
    arst_n = 1'b0;
    @(negedge mclk);
    chk1("mid reset fault", 1'b0, lamp_fault_code);
    chk1("mid reset busy", 1'b1, shade_busy);
    chk1("mid reset ready", 1'b1, pix_ready);
    arst_n = 1'b1;
    page();
    acquire(8'h41, 1'b0);
    end_of_test();
  end
endmodule : tb
